// [sio_defines.svh]
`ifndef SIO_DEFINES_SVH
`define SIO_DEFINES_SVH

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK   8'h0C
`define REG_MEM_ADDR   8'h10
`define REG_MEM_DATA   8'h14
`define REG_OUT_STATE  8'h18

// Control fields
`define CTRL_W          3
`define CTRL_RESET      3'h0

// Interrupt fields
`define IRQ_W           3
`define IRQ_OVL_ON      0
`define IRQ_OVL_OFF     1
`define IRQ_UPDATE      2
`define IRQ_RESET       3'h0

// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Board geometry
`define NUM_INPUTS      63
`define NUM_OUTPUTS     31
`define OVL_ADDR        6'h3F
`define BIPOLAR_FIRST   26
`define BIPOLAR_COUNT   5
`define COMPACT_INPUTS  24
`define COMPACT_RELAYS  23
`define MEM_DEPTH       4096

`endif

// [sio_pkg.sv]
`default_nettype none
package sio_pkg;

    typedef enum logic [1:0] {
        PLC_IDLE  = 2'h0,
        PLC_FETCH = 2'h1,
        PLC_EXEC  = 2'h3
    } plc_state_t;

    typedef enum logic [1:0] {
        OP_LOAD  = 2'h0,
        OP_AND   = 2'h1,
        OP_OR    = 2'h2,
        OP_STORE = 2'h3
    } plc_op_t;

    typedef struct packed {
        plc_op_t     op;
        logic        invert;
        logic        spare;
        logic [11:0] addr;
    } plc_instr_t;

    typedef struct packed {
        logic compact;
        logic bipolar;
        logic second_fitted;
    } ctrl_t;

    typedef struct packed {
        logic [6:0] addr;
        logic       serial_output_stream;
        logic       shift_strobe;
        logic       latch_strobe;
    } serial_bus_t;

endpackage
`default_nettype wire

// [output_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module output_channel (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // Command and sense
    input  wire logic cmd_in,
    input  wire logic overload_in,
    // Driver
    output var  logic drive_out
);
    // Off only while the overload lasts, then back to the command
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            drive_out <= 1'b0;
        else
            drive_out <= cmd_in & ~overload_in; // [RULE_05]
    end

    property p_overload_off;
        @(posedge clk_sys_in) disable iff (rst_in)
        overload_in |=> !drive_out;
    endproperty
    a_overload_off: assert property (p_overload_off) // [RULE_05]
        else $error("output driven during overload");

    property p_resume;
        @(posedge clk_sys_in) disable iff (rst_in)
        (cmd_in && !overload_in) |=> drive_out;
    endproperty
    a_resume: assert property (p_resume) // [RULE_05]
        else $error("output did not resume after overload");
endmodule // output_channel
`default_nettype wire

// [serial_plc_io_expander.sv]
// Operation
// RULE_01: Board returns addressed input on own line
// RULE_02: Second board uses its own return line
// RULE_03: Interface forwards only the selected line
// RULE_04: Serial stream shifts into 31 parallel outputs
// RULE_05: Overloaded output off only during overload
// RULE_06: Overcurrent reported at input 63, no stop
// RULE_07: Processor drives boards only bit-serially
// RULE_08: Variant with 26 unipolar, 5 bipolar outputs
// RULE_09: PLC states kept in 4k x 1 memory
// RULE_10: One-bit PLC runs ROM, addresses from processor
// RULE_11: Processor moves states to and from memory
// RULE_12: Compact variant: 24 inputs, 24 relays (code: 23 relay outputs plus estop_out)
// RULE_13: Outputs hold until a new update completes
`timescale 1ns/1ps
`default_nettype none
`include "sio_defines.svh"
module serial_plc_io_expander #(
    parameter int NUM_INPUTS  = `NUM_INPUTS,
    parameter int NUM_OUTPUTS = `NUM_OUTPUTS,
    parameter int MEM_DEPTH   = `MEM_DEPTH
) (
    // Clock and reset
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_in,
    // AXI4-Lite slave
    input  wire logic [7:0]                  s_axi_awaddr_in,
    input  wire logic                        s_axi_awvalid_in,
    output var  logic                        s_axi_awready_out,
    input  wire logic [31:0]                 s_axi_wdata_in,
    input  wire logic [3:0]                  s_axi_wstrb_in,
    input  wire logic                        s_axi_wvalid_in,
    output var  logic                        s_axi_wready_out,
    output var  logic [1:0]                  s_axi_bresp_out,
    output var  logic                        s_axi_bvalid_out,
    input  wire logic                        s_axi_bready_in,
    input  wire logic [7:0]                  s_axi_araddr_in,
    input  wire logic                        s_axi_arvalid_in,
    output var  logic                        s_axi_arready_out,
    output var  logic [31:0]                 s_axi_rdata_out,
    output var  logic [1:0]                  s_axi_rresp_out,
    output var  logic                        s_axi_rvalid_out,
    input  wire logic                        s_axi_rready_in,
    output var  logic                        irq_out,
    // Serial bus to and from the processor
    input  wire sio_pkg::serial_bus_t        serial_bus_in,
    output var  logic                        first_board_return_line_out,
    output var  logic                        second_board_return_line_out,
    output var  logic                        processor_serial_input_out,
    // Machine side
    input  wire logic [NUM_INPUTS-1:0]       programmable_machine_inputs_in,
    input  wire logic [NUM_INPUTS-1:0]       second_board_inputs_in,
    input  wire logic [`COMPACT_INPUTS-1:0]  compact_isolated_inputs_in,
    input  wire logic [NUM_OUTPUTS:0]        overload_sense_in,
    output var  logic [NUM_OUTPUTS-1:0]      machine_outputs_out,
    output var  logic [`BIPOLAR_COUNT-1:0]   bipolar_sink_out,
    output var  logic [`COMPACT_RELAYS-1:0]  compact_relay_outputs_out,
    output var  logic                        estop_out,
    // PLC program
    input  wire logic                        plc_step_in,
    input  wire logic [11:0]                 plc_prog_addr_in,
    output var  logic [11:0]                 plc_program_rom_addr_out,
    input  wire sio_pkg::plc_instr_t         plc_program_rom_data_in
);
    import sio_pkg::*;

    localparam int NCH = NUM_OUTPUTS + 1;
    localparam int MAW = $clog2(MEM_DEPTH);

    function automatic logic reg_known(input logic [7:0] a);
        return a == `REG_CTRL || a == `REG_STATUS || a == `REG_IRQ_STATUS ||
               a == `REG_IRQ_MASK || a == `REG_MEM_ADDR ||
               a == `REG_MEM_DATA || a == `REG_OUT_STATE;
    endfunction

    // Position 63 carries the overload flag instead of a terminal
    function automatic logic pick_input(input logic [NUM_INPUTS-1:0] ins,
                                        input logic [5:0] a, input logic ovl);
        if (a == `OVL_ADDR)
            return ovl;
        else if (32'(a) < NUM_INPUTS)
            return ins[a];
        else
            return 1'b0;
    endfunction

    // Bus slave state
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    ctrl_t       ctrl;
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] irq_mask;
    logic [MAW-1:0]    mem_addr;

    // Machine and PLC state
    logic [NCH-1:0] shift_reg;
    logic [NCH-1:0] commanded;
    logic [NCH-1:0] drive;
    logic           ovl_any;
    logic           acc;
    plc_state_t     plc_state;
    logic           state_mem [MEM_DEPTH];

    wire aw_take  = s_axi_awvalid_in & s_axi_awready_out;
    wire w_take   = s_axi_wvalid_in & s_axi_wready_out;
    wire do_write = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;
    wire wr_ok    = do_write & reg_known(aw_addr);
    wire lane0    = w_strb[0];
    wire wr_ctrl  = wr_ok & lane0 & (aw_addr == `REG_CTRL);
    wire wr_clr   = wr_ok & lane0 & (aw_addr == `REG_IRQ_STATUS);
    wire wr_mask  = wr_ok & lane0 & (aw_addr == `REG_IRQ_MASK);
    wire wr_maddr = wr_ok & (aw_addr == `REG_MEM_ADDR);
    wire wr_mem   = wr_ok & lane0 & (aw_addr == `REG_MEM_DATA);
    wire ar_take  = s_axi_arvalid_in & s_axi_arready_out;
    wire rd_ok    = reg_known(s_axi_araddr_in);

    wire [31:0] rd_word =
        (s_axi_araddr_in == `REG_CTRL)       ? 32'(ctrl) :
        (s_axi_araddr_in == `REG_STATUS)     ? 32'({acc, plc_state != PLC_IDLE, ovl_any}) :
        (s_axi_araddr_in == `REG_IRQ_STATUS) ? 32'(irq_status) :
        (s_axi_araddr_in == `REG_IRQ_MASK)   ? 32'(irq_mask) :
        (s_axi_araddr_in == `REG_MEM_ADDR)   ? 32'(mem_addr) :
        (s_axi_araddr_in == `REG_MEM_DATA)   ? 32'(state_mem[mem_addr]) :
        (s_axi_araddr_in == `REG_OUT_STATE)  ? 32'(commanded) : 32'h0000_0000;

    // Compact boards answer their isolated inputs, plus the overload flag at position 63
    wire [NUM_INPUTS-1:0] first_ins = ctrl.compact ?
        NUM_INPUTS'(compact_isolated_inputs_in) : programmable_machine_inputs_in;
    wire first_pick  = pick_input(first_ins, serial_bus_in.addr[5:0], ovl_any);
    wire second_pick = ctrl.second_fitted & ~ctrl.compact &
        pick_input(second_board_inputs_in, serial_bus_in.addr[5:0], ovl_any);
    wire board_sel   = serial_bus_in.addr[6];
    wire ovl_now     = |overload_sense_in;

    wire [`IRQ_W-1:0] events;
    assign events[`IRQ_OVL_ON]  = ovl_now & ~ovl_any;
    assign events[`IRQ_OVL_OFF] = ~ovl_now & ovl_any;
    assign events[`IRQ_UPDATE]  = serial_bus_in.latch_strobe;
    // A new event beats a clear in the same cycle
    wire [`IRQ_W-1:0] next_irq_status =
        (irq_status & ~(wr_clr ? w_data[`IRQ_W-1:0] : `IRQ_RESET)) | events;

    plc_instr_t instr;
    assign instr = plc_program_rom_data_in;
    wire operand  = state_mem[instr.addr[MAW-1:0]] ^ instr.invert;
    wire next_acc = (instr.op == OP_LOAD) ? operand :
                    (instr.op == OP_AND)  ? (acc & operand) :
                    (instr.op == OP_OR)   ? (acc | operand) : acc;
    wire plc_store = (plc_state == PLC_EXEC) & (instr.op == OP_STORE);

    // Write channel: address and data may arrive in either order
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                s_axi_awready_out <= 1'b0;
            if (w_take)
                s_axi_wready_out <= 1'b0;
            if (do_write)
            begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= reg_known(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid_out && s_axi_bready_in)
            begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (aw_take)
            aw_addr <= s_axi_awaddr_in;
        if (w_take)
        begin
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
        end
    end

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= `RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_word;
            s_axi_rresp_out   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid_out && s_axi_rready_in)
        begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
        end
    end

    // Control, interrupt and memory pointer registers
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ctrl       <= `CTRL_RESET;
            irq_status <= `IRQ_RESET;
            irq_mask   <= `IRQ_RESET;
            mem_addr   <= '0;
            irq_out    <= 1'b0;
            ovl_any    <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= w_data[`CTRL_W-1:0];
            if (wr_mask)
                irq_mask <= w_data[`IRQ_W-1:0];
            if (wr_maddr)
                mem_addr <= w_data[MAW-1:0];
            irq_status <= next_irq_status;
            irq_out    <= |(next_irq_status & (wr_mask ? w_data[`IRQ_W-1:0] : irq_mask));
            ovl_any    <= ovl_now; // [RULE_06]
        end
    end

    // Software write wins over a PLC store to the same cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_mem)
            state_mem[mem_addr] <= w_data[0]; // [RULE_09] [RULE_11]
        else if (plc_store)
            state_mem[instr.addr[MAW-1:0]] <= acc ^ instr.invert; // [RULE_09]
    end

    // One-bit PLC: the processor supplies each program address
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            plc_state                <= PLC_IDLE;
            plc_program_rom_addr_out <= 12'h000;
            acc                      <= 1'b0;
        end
        else
        begin
            unique case (plc_state)
                PLC_IDLE:
                    if (plc_step_in)
                    begin
                        plc_program_rom_addr_out <= plc_prog_addr_in; // [RULE_10]
                        plc_state                <= PLC_FETCH;
                    end
                PLC_FETCH:
                    plc_state <= PLC_EXEC;
                PLC_EXEC:
                begin
                    acc       <= next_acc; // [RULE_10]
                    plc_state <= PLC_IDLE;
                end
                default:
                    plc_state <= PLC_IDLE;
            endcase
        end
    end

    // Return lines and the interface board's selector
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            first_board_return_line_out  <= 1'b0;
            second_board_return_line_out <= 1'b0;
            processor_serial_input_out   <= 1'b0;
        end
        else
        begin
            first_board_return_line_out  <= first_pick;  // [RULE_01] [RULE_06]
            second_board_return_line_out <= second_pick; // [RULE_02]
            processor_serial_input_out   <= board_sel ? second_pick : first_pick; // [RULE_03]
        end
    end

    // Shift chain is separate from the outputs, so outputs hold meanwhile
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            shift_reg <= '0;
            commanded <= '0;
        end
        else
        begin
            if (serial_bus_in.shift_strobe)
                shift_reg <= {shift_reg[NCH-2:0], serial_bus_in.serial_output_stream}; // [RULE_04] [RULE_07]
            if (serial_bus_in.latch_strobe)
                commanded <= shift_reg; // [RULE_13]
        end
    end

    // One supervised channel per output; the top one is the stop output
    for (genvar i = 0; i < NCH; i++)
    begin : g_chan
        output_channel u_chan (
            .clk_sys_in  (clk_sys_in),
            .rst_in      (rst_in),
            .cmd_in      (commanded[i]),
            .overload_in (overload_sense_in[i]),
            .drive_out   (drive[i])
        );
    end

    // Variant routing of the supervised drivers
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            machine_outputs_out       <= '0;
            bipolar_sink_out          <= '0;
            compact_relay_outputs_out <= '0;
            estop_out                 <= 1'b0;
        end
        else
        begin
            machine_outputs_out <= ctrl.compact ? '0 : drive[NUM_OUTPUTS-1:0]; // [RULE_04]
            bipolar_sink_out <= (ctrl.bipolar & ~ctrl.compact) ?
                ~commanded[`BIPOLAR_FIRST +: `BIPOLAR_COUNT] &
                ~overload_sense_in[`BIPOLAR_FIRST +: `BIPOLAR_COUNT] : '0; // [RULE_08]
            compact_relay_outputs_out <= ctrl.compact ? drive[`COMPACT_RELAYS-1:0] : '0; // [RULE_12]
            estop_out <= drive[NUM_OUTPUTS]; // [RULE_06] [RULE_08] [RULE_12]
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // Checked against the terminal itself, not the picking logic
    property p_first_ret;
        (!rst_in && !ctrl.compact && serial_bus_in.addr[5:0] != `OVL_ADDR)
            |=> first_board_return_line_out ==
                $past(programmable_machine_inputs_in[serial_bus_in.addr[5:0]]);
    endproperty
    a_first_ret: assert property (p_first_ret) // [RULE_01]
        else $error("first return line wrong");

    property p_second_ret;
        !ctrl.second_fitted |=> !second_board_return_line_out;
    endproperty
    a_second_ret: assert property (p_second_ret) // [RULE_02]
        else $error("second return line active without second board");

    property p_select;
        board_sel |=> processor_serial_input_out == second_board_return_line_out;
    endproperty
    a_select: assert property (p_select) // [RULE_03]
        else $error("selector did not forward second line");

    property p_shift;
        serial_bus_in.shift_strobe && !serial_bus_in.latch_strobe
            |=> shift_reg[0] == $past(serial_bus_in.serial_output_stream);
    endproperty
    a_shift: assert property (p_shift) // [RULE_04]
        else $error("serial bit not shifted in");

    property p_ovl_report;
        (serial_bus_in.addr[5:0] == `OVL_ADDR && !board_sel)
            |=> first_board_return_line_out == $past(ovl_any);
    endproperty
    a_ovl_report: assert property (p_ovl_report) // [RULE_06]
        else $error("overload not reported at position 63");

    property p_hold;
        !serial_bus_in.latch_strobe |=> $stable(commanded);
    endproperty
    a_hold: assert property (p_hold) // [RULE_13]
        else $error("outputs changed without an update");

    sequence s_step;
        plc_step_in && plc_state == PLC_IDLE;
    endsequence
    sequence s_run;
        plc_state == PLC_FETCH ##1 plc_state == PLC_EXEC ##1 plc_state == PLC_IDLE;
    endsequence
    property p_plc_step;
        s_step |=> (plc_program_rom_addr_out == $past(plc_prog_addr_in)) and s_run;
    endproperty
    a_plc_step: assert property (p_plc_step) // [RULE_10]
        else $error("PLC step sequence broken");

    property p_store;
        (plc_store && !wr_mem)
            |=> state_mem[$past(instr.addr[MAW-1:0])] == $past(acc ^ instr.invert);
    endproperty
    a_store: assert property (p_store) // [RULE_09]
        else $error("PLC store lost");

    property p_compact;
        ctrl.compact |=> machine_outputs_out == '0;
    endproperty
    a_compact: assert property (p_compact) // [RULE_12]
        else $error("unipolar outputs driven in compact variant");
endmodule // serial_plc_io_expander
`default_nettype wire

// [proc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module proc_model
    import sio_pkg::*;
(
    // Clock
    input  wire logic        clk_sys_in,
    // Serial bus and program store
    output var  serial_bus_t bus_out,
    input  wire logic [11:0] rom_addr_in,
    output var  plc_instr_t  rom_data_out
);
    initial bus_out = '0;

    // Input address driven on all seven address lines in one cycle
    task automatic set_addr(input logic [6:0] a);
        @(posedge clk_sys_in);
        bus_out.addr <= a;
    endtask

    // First bit sent lands on the estop channel
    task automatic send_word(input logic [31:0] w, input logic latch);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge clk_sys_in);
            bus_out.serial_output_stream <= w[i];
            bus_out.shift_strobe <= 1'b1;
        end
        @(posedge clk_sys_in);
        bus_out.shift_strobe <= 1'b0;
        // Data line toggles once unqualified, so stale bits never look valid
        bus_out.serial_output_stream <= ~w[0];
        bus_out.latch_strobe <= latch;
        @(posedge clk_sys_in);
        bus_out.latch_strobe <= 1'b0;
    endtask

    // Synchronous program store, one cycle behind the address
    always @(posedge clk_sys_in)
        rom_data_out <= (rom_addr_in == 12'h000) ? plc_instr_t'{OP_LOAD, 1'b0, 1'b0, 12'h005}
                                                 : plc_instr_t'{OP_STORE, 1'b1, 1'b0, 12'h006};
endmodule // proc_model
`default_nettype wire

// [serial_plc_io_expander_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sio_defines.svh"
module serial_plc_io_expander_bench;
    import sio_pkg::*;
    // Clock, reset, register bus
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in = 4'hF;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic        s_axi_arready_out, s_axi_rvalid_out, irq_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rsp;
    // Serial bus and machine side
    serial_bus_t serial_bus_in;
    logic        first_board_return_line_out, second_board_return_line_out;
    logic        processor_serial_input_out, estop_out, plc_step_in = 1'b0;
    logic [62:0] programmable_machine_inputs_in = 63'h1234_5678_9ABC_DEF0;
    logic [62:0] second_board_inputs_in = 63'h2DCB_A987_6543_210F;
    logic [23:0] compact_isolated_inputs_in = 24'hA5C396;
    logic [31:0] overload_sense_in = 32'h0;
    logic [30:0] machine_outputs_out;
    logic [4:0]  bipolar_sink_out;
    logic [22:0] compact_relay_outputs_out;
    logic [11:0] plc_prog_addr_in = 12'h000, plc_program_rom_addr_out;
    plc_instr_t  plc_program_rom_data_in;
    logic [31:0] rd, word;
    logic [5:0]  pos [4] = '{6'h00, 6'h01, 6'h1F, 6'h3E};
    int          err_count = 0, n_checks = 0, cyc = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    serial_plc_io_expander i_dut (.*);
    proc_model i_proc (
        .clk_sys_in,
        .bus_out      (serial_bus_in),
        .rom_addr_in  (plc_program_rom_addr_out),
        .rom_data_out (plc_program_rom_data_in)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out)
                s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out)
                s_axi_wvalid_in <= 1'b0;
        end
        while (s_axi_bvalid_out !== 1'b1);
        s_axi_bready_in <= 1'b0;
        rsp = s_axi_bresp_out;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
            if (s_axi_arready_out)
                s_axi_arvalid_in <= 1'b0;
        end
        while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b0;
        rd = s_axi_rdata_out;
        rsp = s_axi_rresp_out;
    endtask

    task automatic memw(input logic [11:0] a, input logic d);
        axw(`REG_MEM_ADDR, {20'h0, a});
        axw(`REG_MEM_DATA, {31'h0, d});
    endtask

    // Settle past the launching edge before looking
    task automatic wcy(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic step(input logic [11:0] a);
        @(posedge clk_sys_in);
        plc_step_in <= 1'b1;
        plc_prog_addr_in <= a;
        @(posedge clk_sys_in);
        plc_step_in <= 1'b0;
        wcy(4);
    endtask

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            results();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        axr(`REG_IRQ_MASK);
        chk(rd, 32'h0);
        axr(8'h1C);
        chk(rsp, `RESP_SLVERR);
        axw(8'h20, 32'h1);
        chk(rsp, `RESP_SLVERR);
        $display("test registers done");

        axw(`REG_CTRL, 32'h1);
        foreach (pos[i])
        begin
            i_proc.set_addr({1'b0, pos[i]});
            wcy(3);
            chk({first_board_return_line_out, processor_serial_input_out},
                {2{programmable_machine_inputs_in[pos[i]]}});
            i_proc.set_addr({1'b1, pos[i]});
            wcy(3);
            chk({second_board_return_line_out, processor_serial_input_out},
                {2{second_board_inputs_in[pos[i]]}});
        end
        $display("test inputs done");

        axw(`REG_IRQ_MASK, 32'h4);
        word = 32'hDA5A_123F;
        i_proc.send_word(word, 1'b1);
        wcy(3);
        chk({estop_out, machine_outputs_out}, word);
        chk(irq_out, 32'h1);
        axr(`REG_OUT_STATE);
        chk(rd, word);
        i_proc.send_word(32'h0, 1'b0);
        wcy(3);
        chk({estop_out, machine_outputs_out}, word);
        axw(`REG_IRQ_STATUS, 32'h4);
        wcy(2);
        chk(irq_out, 32'h0);
        $display("test outputs done");

        @(posedge clk_sys_in);
        overload_sense_in <= 32'h0000_0008;
        i_proc.set_addr({1'b0, `OVL_ADDR});
        wcy(3);
        chk({estop_out, machine_outputs_out}, word & ~32'h8);
        chk(processor_serial_input_out, 32'h1);
        axr(`REG_IRQ_STATUS);
        chk(rd & 32'h1, 32'h1);
        @(posedge clk_sys_in);
        overload_sense_in <= 32'h0;
        wcy(4);
        chk({estop_out, machine_outputs_out}, word);
        axr(`REG_IRQ_STATUS);
        chk(rd, 32'h3);
        $display("test overload done");

        memw(12'hFFF, 1'b1);
        axr(`REG_MEM_DATA);
        chk(rd, 32'h1);
        memw(12'h005, 1'b1);
        memw(12'h006, 1'b1);
        step(12'h000);
        axr(`REG_STATUS);
        chk(rd, 32'h4);
        step(12'h001);
        chk(plc_program_rom_addr_out, 32'h1);
        axr(`REG_MEM_DATA);
        chk(rd, 32'h0);
        $display("test plc done");

        axw(`REG_CTRL, 32'h2);
        wcy(3);
        chk(bipolar_sink_out, {27'h0, ~word[30:26]});
        axw(`REG_CTRL, 32'h4);
        i_proc.set_addr(7'h05);
        wcy(3);
        chk(machine_outputs_out, 32'h0);
        chk(compact_relay_outputs_out, {9'h0, word[22:0]});
        chk(estop_out, {31'h0, word[31]});
        chk(processor_serial_input_out, compact_isolated_inputs_in[5]);
        $display("test variants done");
        results();
    end
endmodule // serial_plc_io_expander_bench
`default_nettype wire
